/* File: src/lapse_timer.sv */
// Restartable lapse counter used by both watchdogs.
// Assumes restart and enable come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lapse_timer #(
  parameter int LIMIT = 1000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic restart,
  // Result
  output logic expired
);
  import supervision_pkg::*;

  logic [TIMER_W-1:0] count_r, count_nxt;
  logic expired_r, expired_nxt;

  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(LIMIT - 1);

  always_comb begin
    count_nxt = count_r;
    expired_nxt = 1'b0;
    if (!enable || restart) begin
      count_nxt = '0;
    end else if (count_r == LAST) begin
      // Fires once, then restarts so a held-off reaction repeats
      expired_nxt = 1'b1;
      count_nxt = '0;
    end else begin
      count_nxt = count_r + TIMER_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_r <= '0;
      expired_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;
endmodule
`default_nettype wire

/* File: src/slave_supervision.sv */
// Slave supervision: status word, communication monitor / watchdog,
// nibble toggle watchdog and write protection of profile extension one.
// Assumes request strobes are one-cycle pulses from the protocol engine on
// ref_clk; the parameter port bit arrives from a pin and is synchronised.
//
// Behaviour
// - Status bit zero: volatile address or busy
// - Set after delete-address nonzero; held during writes
// - Status bit one: firmware area parity error
// - Status bit two always reads zero
// - Status bit three: memory content corrupted
// - Status word returned on read-status request
// - Outside watchdog mode, silence past 40.960 ms flags, lights LED
// - Data or parameter traffic restarts, LED off
// - Monitor starts on parameter write, address nonzero
// - Reset or delete-address deactivates the monitor
// - Watchdog mode from flag or port bit
// - Watchdog timeout resets outputs, blocks, reinitialises
// - Data refused until next parameter write
// - Toggle watchdog enabled by first data output
// - Toggle watchdog only in nibble mode
// - No toggle for 327 ms: full reset
// - Locked: reply from locked copy
// - Extended mode keeps user bit three
// - Locked mismatching write ignored, no reply
// - Unlocked: reply entirely from user register
// - Unlocked writes answered and start memory write
`timescale 1ns/1ps
`default_nettype none
module slave_supervision #(
  parameter int COMM_LIMIT = supervision_pkg::COMM_TIMEOUT_CYC,
  parameter int TOGGLE_LIMIT = supervision_pkg::TOGGLE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Decoded master requests, one-cycle pulses
  input wire logic read_status_call,
  input wire logic delete_address_call,
  input wire logic data_exchange_call,
  input wire logic write_param_call,
  input wire logic data_output_event,
  input wire logic toggle_supervised_bit,
  input wire logic read_ext_one_call,
  input wire logic write_ext_one_call,
  input wire logic [3:0] write_ext_one_data,
  input wire logic address_stored_event,
  // Configuration and memory state
  input wire logic [4:0] slave_address,
  input wire logic address_volatile,
  input wire logic nvm_write_busy,
  input wire logic firmware_parity_fault,
  input wire logic nvm_corrupt,
  input wire logic watchdog_enable_flag,
  input wire logic port0_watchdog_select,
  input wire logic ext_addr_mode,
  input wire logic ext_addr_nibble_mode,
  input wire logic [3:0] profile_code,
  input wire logic ext_code_lock_flag,
  input wire logic [3:0] locked_extension_one_copy,
  input wire logic [3:0] profile_extension_one,
  // Pin
  input wire logic parameter_port_bit_zero,
  // Status reply
  output logic status_reply_valid,
  output logic [3:0] slave_status_word,
  // Extension code reply and memory write
  output logic ext_one_reply_valid,
  output logic [3:0] ext_one_reply,
  output logic nvm_write_start,
  output logic [3:0] nvm_write_data,
  // Supervision
  output logic red_status_led,
  output logic no_exchange_flag,
  output logic watchdog_reset,
  output logic data_exchange_blocked,
  output logic data_exchange_accept,
  output logic toggle_watchdog_armed
);
  import supervision_pkg::*;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic p0_meta_r, p0_sync_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      p0_meta_r <= 1'b0;
      p0_sync_r <= 1'b0;
    end else begin
      p0_meta_r <= parameter_port_bit_zero;
      p0_sync_r <= p0_meta_r;
    end
  end

  // ****************************************
  // Common terms
  // ****************************************
  logic addr_valid;
  logic wd_mode;
  logic comm_expired;
  logic toggle_expired;
  logic wd_fire;
  logic data_taken;
  logic traffic;
  logic data_exchange_blocked_r;

  assign addr_valid = (slave_address != ADDR_NONE);
  assign wd_mode = watchdog_enable_flag | (port0_watchdog_select & p0_sync_r);
  // Blocked data exchanges are refused and do not feed the monitor
  assign data_taken = data_exchange_call & ~data_exchange_blocked_r;
  assign traffic = data_taken | write_param_call;

  // ****************************************
  // Status word
  // ****************************************
  logic delete_address_call_volatile_r, delete_address_call_volatile_nxt;
  logic status_valid_r, status_valid_nxt;
  logic [3:0] status_r, status_nxt;
  logic write_pending;

  always_comb begin
    delete_address_call_volatile_nxt = delete_address_call_volatile_r;
    // Clear first so a same-cycle delete-address wins
    if (address_stored_event) begin
      delete_address_call_volatile_nxt = 1'b0;
    end
    if (delete_address_call && addr_valid) begin
      delete_address_call_volatile_nxt = 1'b1;
    end
  end

  always_comb begin
    status_valid_nxt = read_status_call;
    status_nxt = status_r;
    if (read_status_call) begin
      status_nxt = STATUS_RESET;
      status_nxt[ST_VOLATILE_BIT] = delete_address_call_volatile_r | address_volatile | write_pending;
      status_nxt[ST_PARITY_BIT] = firmware_parity_fault;
      status_nxt[ST_UNUSED_BIT] = 1'b0;
      status_nxt[ST_CORRUPT_BIT] = nvm_corrupt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      delete_address_call_volatile_r <= 1'b0;
      status_valid_r <= 1'b0;
      status_r <= STATUS_RESET;
    end else begin
      delete_address_call_volatile_r <= delete_address_call_volatile_nxt;
      status_valid_r <= status_valid_nxt;
      status_r <= status_nxt;
    end
  end

  // ****************************************
  // Communication monitor
  // ****************************************
  monitor_state_t mon_r, mon_nxt;
  logic led_r, led_nxt;

  always_comb begin
    mon_nxt = mon_r;
    case (mon_r)
      MON_OFF: begin
        if (write_param_call && addr_valid) begin
          mon_nxt = MON_RUN;
        end
      end
      MON_RUN: begin
        if (comm_expired && !traffic) begin
          mon_nxt = MON_LAPSED;
        end
      end
      MON_LAPSED: begin
        if (traffic) begin
          mon_nxt = MON_RUN;
        end
      end
      default: begin
        mon_nxt = MON_OFF;
      end
    endcase
    // Watchdog reset is a full IC reset and ends supervision too
    if (delete_address_call || wd_fire) begin
      mon_nxt = MON_OFF;
    end
  end

  always_comb begin
    led_nxt = (mon_nxt == MON_LAPSED);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mon_r <= MON_OFF;
      led_r <= 1'b0;
    end else begin
      mon_r <= mon_nxt;
      led_r <= led_nxt;
    end
  end

  // Counts ref_clk cycles; limit is derived from the clock rate
  lapse_timer #(
    .LIMIT(COMM_LIMIT)
  ) comm_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(mon_r == MON_RUN),
    .restart(traffic),
    .expired(comm_expired)
  );

  // ****************************************
  // Toggle watchdog
  // ****************************************
  logic toggle_en_r, toggle_en_nxt;
  logic last_toggle_r, last_toggle_nxt;
  logic toggle_active;
  logic toggle_seen;

  assign toggle_active = toggle_en_r & ext_addr_nibble_mode
                         & (profile_code == NIBBLE_PROFILE_CODE) & wd_mode;
  assign toggle_seen = data_output_event & (toggle_supervised_bit != last_toggle_r);

  always_comb begin
    toggle_en_nxt = toggle_en_r;
    last_toggle_nxt = last_toggle_r;
    if (data_output_event) begin
      last_toggle_nxt = toggle_supervised_bit;
      if (addr_valid) begin
        toggle_en_nxt = 1'b1;
      end
    end
    if (delete_address_call || wd_fire) begin
      toggle_en_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      toggle_en_r <= 1'b0;
      last_toggle_r <= 1'b0;
    end else begin
      toggle_en_r <= toggle_en_nxt;
      last_toggle_r <= last_toggle_nxt;
    end
  end

  // The enabling event itself starts a fresh window
  lapse_timer #(
    .LIMIT(TOGGLE_LIMIT)
  ) toggle_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(toggle_active),
    .restart(toggle_seen | (data_output_event & ~toggle_en_r)),
    .expired(toggle_expired)
  );

  // ****************************************
  // Watchdog reset and data blocking
  // ****************************************
  logic wd_reset_r, wd_reset_nxt;
  logic blocked_r, blocked_nxt;
  logic accept_r, accept_nxt;

  assign wd_fire = (comm_expired & (mon_r == MON_RUN) & ~traffic & wd_mode)
                   | (toggle_expired & toggle_active);
  assign data_exchange_blocked_r = blocked_r;

  always_comb begin
    wd_reset_nxt = wd_fire;
    blocked_nxt = blocked_r;
    if (write_param_call) begin
      blocked_nxt = 1'b0;
    end
    // Set wins over a same-cycle parameter write
    if (wd_fire) begin
      blocked_nxt = 1'b1;
    end
    accept_nxt = data_taken;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wd_reset_r <= 1'b0;
      blocked_r <= 1'b0;
      accept_r <= 1'b0;
    end else begin
      wd_reset_r <= wd_reset_nxt;
      blocked_r <= blocked_nxt;
      accept_r <= accept_nxt;
    end
  end

  // ****************************************
  // Profile extension one protection
  // ****************************************
  logic ext_valid_r, ext_valid_nxt;
  logic [3:0] ext_reply_r, ext_reply_nxt;
  logic wr_start_r, wr_start_nxt;
  logic [3:0] wr_data_r, wr_data_nxt;
  logic [3:0] protect_mask;
  logic write_ok;

  // In extended mode bit three is the user's A/B selector
  always_comb begin
    protect_mask = 4'hF;
    if (ext_addr_mode) begin
      protect_mask[AB_SELECT_BIT] = 1'b0;
    end
  end

  assign write_ok = !ext_code_lock_flag
                    || (((write_ext_one_data ^ locked_extension_one_copy) & protect_mask) == NIBBLE_ZERO);
  assign write_pending = wr_start_r | nvm_write_busy;

  always_comb begin
    ext_valid_nxt = 1'b0;
    ext_reply_nxt = ext_reply_r;
    wr_start_nxt = 1'b0;
    wr_data_nxt = wr_data_r;
    if (read_ext_one_call) begin
      ext_valid_nxt = 1'b1;
      if (ext_code_lock_flag) begin
        ext_reply_nxt = (locked_extension_one_copy & protect_mask)
                        | (profile_extension_one & ~protect_mask);
      end else begin
        ext_reply_nxt = profile_extension_one;
      end
    end else if (write_ext_one_call && write_ok) begin
      ext_valid_nxt = 1'b1;
      ext_reply_nxt = write_ext_one_data;
      wr_start_nxt = 1'b1;
      wr_data_nxt = write_ext_one_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_valid_r <= 1'b0;
      ext_reply_r <= NIBBLE_ZERO;
      wr_start_r <= 1'b0;
      wr_data_r <= NIBBLE_ZERO;
    end else begin
      ext_valid_r <= ext_valid_nxt;
      ext_reply_r <= ext_reply_nxt;
      wr_start_r <= wr_start_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign status_reply_valid = status_valid_r;
  assign slave_status_word = status_r;
  assign ext_one_reply_valid = ext_valid_r;
  assign ext_one_reply = ext_reply_r;
  assign nvm_write_start = wr_start_r;
  assign nvm_write_data = wr_data_r;
  assign red_status_led = led_r;
  assign no_exchange_flag = led_r;
  assign watchdog_reset = wd_reset_r;
  assign data_exchange_blocked = blocked_r;
  assign data_exchange_accept = accept_r;
  assign toggle_watchdog_armed = toggle_en_r;
endmodule
`default_nettype wire

/* File: src/supervision_pkg.sv */
// Shared constants for the slave supervision block: status layout,
// watchdog timing and profile codes.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
package supervision_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_KHZ = 10000;
  // No-exchange window, printed figure in microseconds
  localparam int COMM_TIMEOUT_US = 40960;
  // Toggle supervision window, printed figure in milliseconds
  localparam int TOGGLE_TIMEOUT_MS = 327;
  // Strictly more than the window, so one cycle past the exact count
  localparam int COMM_TIMEOUT_CYC = (COMM_TIMEOUT_US * (CLK_KHZ / 1000)) + 1;
  localparam int TOGGLE_TIMEOUT_CYC = (TOGGLE_TIMEOUT_MS * CLK_KHZ) + 1;
  localparam int TIMER_W = 22;

  // ****************************************
  // Status word layout
  // ****************************************
  localparam int ST_VOLATILE_BIT = 0;
  localparam int ST_PARITY_BIT = 1;
  localparam int ST_UNUSED_BIT = 2;
  localparam int ST_CORRUPT_BIT = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;

  // ****************************************
  // Addresses and profile codes
  // ****************************************
  localparam logic [4:0] ADDR_NONE = 5'h00;
  localparam logic [3:0] NIBBLE_PROFILE_CODE = 4'hA;
  localparam int AB_SELECT_BIT = 3;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // ****************************************
  // Communication monitor states
  // ****************************************
  typedef enum logic [1:0] {
    MON_OFF = 2'b00,
    MON_RUN = 2'b01,
    MON_LAPSED = 2'b10
  } monitor_state_t;

endpackage

/* File: test/master_model.sv */
// Master side: issues one-cycle request pulses at the falling edge.
// Assumes the block answers on the taken edge, before the request is released.
`timescale 1ns/1ps
`default_nettype none
module master_model (
  // Clock
  input wire logic ref_clk,
  // Requests
  output logic read_status_call, delete_address_call, data_exchange_call, write_param_call,
  output logic data_output_event, read_ext_one_call, write_ext_one_call, toggle_supervised_bit,
  output logic [3:0] write_ext_one_data,
  // Replies
  input wire logic ext_one_reply_valid,
  input wire logic [3:0] ext_one_reply
);
  logic [6:0] req_r = 7'h00;
  assign {write_ext_one_call, read_ext_one_call, data_output_event, write_param_call,
    data_exchange_call, delete_address_call, read_status_call} = req_r;
  initial begin
    toggle_supervised_bit = 1'b0;
    write_ext_one_data = 4'h0;
  end
  // Codes: 0 status, 1 delete, 2 data, 3 param, 4 nibble, 5 read ext, 6 write ext
  task automatic send(input int k, input logic [3:0] d);
    @(negedge ref_clk);
    req_r = 7'h01 << k;
    write_ext_one_data = d;
    toggle_supervised_bit = d[0];
    @(negedge ref_clk);
    req_r = 7'h00;
    // Released lines flip so a stale value never passes for a driven one
    write_ext_one_data = ~d;
    toggle_supervised_bit = ~d[0];
  endtask
  task automatic ab_change(input logic b3);
    logic [3:0] cur;
    send(5, 4'h0);
    cur = ext_one_reply_valid ? ext_one_reply : 4'h0;
    send(6, {b3, cur[2:0]});
  endtask
endmodule
`default_nettype wire

/* File: test/supervision_monitor.sv */
// Port-level checks for slave_supervision.
// Assumes one clock, synchronous active-high reset, bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module supervision_monitor #(
  parameter int COMM_LIMIT = supervision_pkg::COMM_TIMEOUT_CYC
) (
  // Clock, reset and requests
  input wire logic ref_clk, rst, read_status_call, data_exchange_call, write_param_call,
  input wire logic read_ext_one_call, write_ext_one_call,
  input wire logic [3:0] write_ext_one_data,
  // Levels
  input wire logic address_volatile, nvm_write_busy, firmware_parity_fault, nvm_corrupt,
  input wire logic ext_addr_mode, ext_code_lock_flag,
  input wire logic [3:0] locked_extension_one_copy, profile_extension_one,
  // Outputs watched
  input wire logic status_reply_valid, ext_one_reply_valid, nvm_write_start, red_status_led,
  input wire logic watchdog_reset, data_exchange_blocked, data_exchange_accept,
  input wire logic [3:0] slave_status_word, ext_one_reply, nvm_write_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  int quiet_r;
  int quiet_nxt;
  logic [3:0] ext_exp;
  // Blocked data traffic does not count, so it must not clear the count
  always_comb begin
    quiet_nxt = quiet_r + 1;
    if (write_param_call || (data_exchange_call && !data_exchange_blocked)) begin
      quiet_nxt = 0;
    end
  end
  always_ff @(posedge ref_clk) begin
    quiet_r <= rst ? 0 : quiet_nxt;
  end
  always_comb begin
    ext_exp = profile_extension_one;
    if (ext_code_lock_flag) begin
      ext_exp = {ext_addr_mode ? profile_extension_one[3] : locked_extension_one_copy[3],
        locked_extension_one_copy[2:0]};
    end
  end
  sequence s_traffic;
    write_param_call || (data_exchange_call && !data_exchange_blocked);
  endsequence
  sequence s_ext_write;
    write_ext_one_call && !read_ext_one_call;
  endsequence
  property p_status_reply;
    read_status_call |=> status_reply_valid && slave_status_word[2] == 1'b0;
  endproperty
  a_status_reply: assert property (p_status_reply) else $error("status reply bad");
  property p_status_bits;
    read_status_call |=> slave_status_word[3] == $past(nvm_corrupt)
      && slave_status_word[1] == $past(firmware_parity_fault);
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status memory bits bad");
  property p_busy_bit;
    read_status_call && (address_volatile || nvm_write_busy) |=> slave_status_word[0];
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("status busy bit low");
  property p_led_off;
    s_traffic |-> ##2 !red_status_led;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led on after traffic");
  property p_led_quiet;
    $rose(red_status_led) |-> quiet_r >= COMM_LIMIT;
  endproperty
  a_led_quiet: assert property (p_led_quiet) else $error("led on too early");
  property p_ext_write_open;
    s_ext_write ##0 !ext_code_lock_flag |=> nvm_write_start && ext_one_reply_valid
      && nvm_write_data == $past(write_ext_one_data);
  endproperty
  a_ext_write_open: assert property (p_ext_write_open) else $error("open write not taken");
  property p_ext_write_locked;
    s_ext_write ##0 ext_code_lock_flag && write_ext_one_data[2:0] != locked_extension_one_copy[2:0]
      |=> !nvm_write_start && !ext_one_reply_valid;
  endproperty
  a_ext_write_locked: assert property (p_ext_write_locked) else $error("locked write taken");
  property p_ext_read;
    read_ext_one_call |=> ext_one_reply_valid && ext_one_reply == $past(ext_exp);
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("extension reply bad");
  property p_refuse;
    data_exchange_call && data_exchange_blocked && !write_param_call |=> !data_exchange_accept;
  endproperty
  a_refuse: assert property (p_refuse) else $error("blocked data accepted");
  property p_wd_block;
    watchdog_reset |-> ##[0:1] data_exchange_blocked;
  endproperty
  a_wd_block: assert property (p_wd_block) else $error("watchdog reset left data open");
endmodule
bind slave_supervision supervision_monitor #(.COMM_LIMIT(COMM_LIMIT)) i_supervision_monitor (
  .ref_clk(ref_clk), .rst(rst), .read_status_call(read_status_call),
  .data_exchange_call(data_exchange_call), .write_param_call(write_param_call),
  .read_ext_one_call(read_ext_one_call), .write_ext_one_call(write_ext_one_call),
  .write_ext_one_data(write_ext_one_data), .address_volatile(address_volatile),
  .nvm_write_busy(nvm_write_busy), .firmware_parity_fault(firmware_parity_fault), .nvm_corrupt(nvm_corrupt),
  .ext_addr_mode(ext_addr_mode), .ext_code_lock_flag(ext_code_lock_flag),
  .locked_extension_one_copy(locked_extension_one_copy), .profile_extension_one(profile_extension_one),
  .status_reply_valid(status_reply_valid), .ext_one_reply_valid(ext_one_reply_valid),
  .nvm_write_start(nvm_write_start), .red_status_led(red_status_led), .watchdog_reset(watchdog_reset),
  .data_exchange_blocked(data_exchange_blocked), .data_exchange_accept(data_exchange_accept),
  .slave_status_word(slave_status_word), .ext_one_reply(ext_one_reply), .nvm_write_data(nvm_write_data)
);
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for slave_supervision driven through master_model.
// Assumes shortened watchdog limits; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import supervision_pkg::*;
  localparam int CL = 20;
  localparam int TL = 30;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic read_status_call, delete_address_call, data_exchange_call, write_param_call, data_output_event;
  logic toggle_supervised_bit, read_ext_one_call, write_ext_one_call, address_stored_event, address_volatile;
  logic nvm_write_busy, firmware_parity_fault, nvm_corrupt, watchdog_enable_flag, port0_watchdog_select;
  logic ext_addr_mode, ext_addr_nibble_mode, ext_code_lock_flag, parameter_port_bit_zero;
  logic status_reply_valid, ext_one_reply_valid, nvm_write_start, red_status_led, no_exchange_flag;
  logic watchdog_reset, data_exchange_blocked, data_exchange_accept, toggle_watchdog_armed;
  logic [3:0] write_ext_one_data, profile_code, locked_extension_one_copy, profile_extension_one;
  logic [3:0] slave_status_word, ext_one_reply, nvm_write_data;
  logic [4:0] slave_address;
  logic wd_seen = 1'b0;
  logic acc_seen = 1'b0;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  slave_supervision #(.COMM_LIMIT(CL), .TOGGLE_LIMIT(TL)) i_slave_supervision (.*);
  master_model i_master_model (.*);
  always #50 ref_clk = ~ref_clk;
  // Sticky capture of one-cycle pulses; the ceiling cuts a hang short
  always @(posedge ref_clk) begin
    // Cleared by each bench reset, so this process is their only driver
    wd_seen <= !rst && (wd_seen || watchdog_reset === 1'b1);
    acc_seen <= !rst && (acc_seen || data_exchange_accept === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic send(input int k, input logic [3:0] d);
    i_master_model.send(k, d);
  endtask
  task automatic rd_st(input logic [3:0] exp);
    send(0, 4'h0);
    chk(slave_status_word, exp);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    idle(8);
    rst = 1'b0;
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [3:0] v;
    {address_stored_event, address_volatile, nvm_write_busy, firmware_parity_fault, nvm_corrupt} = '0;
    {watchdog_enable_flag, port0_watchdog_select, ext_addr_mode, ext_addr_nibble_mode} = '0;
    {ext_code_lock_flag, parameter_port_bit_zero} = '0;
    profile_code = 4'h0;
    locked_extension_one_copy = 4'h3;
    profile_extension_one = 4'h9;
    slave_address = 5'h05;
    do_reset();
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      {address_volatile, nvm_corrupt, firmware_parity_fault, nvm_write_busy} = v;
      rd_st({v[2], 1'b0, v[1], v[0] | v[3]});
    end
    {address_volatile, nvm_corrupt, firmware_parity_fault, nvm_write_busy} = 4'h0;
    send(1, 4'h0);
    rd_st(4'h1);
    address_stored_event = 1'b1;
    idle(1);
    address_stored_event = 1'b0;
    rd_st(4'h0);
    slave_address = 5'h00;
    send(1, 4'h0);
    rd_st(4'h0);
    $display("test status done");
    idle(CL + 5);
    chk({3'h0, red_status_led}, 4'h0);
    send(3, 4'h0);
    idle(CL + 5);
    chk({3'h0, red_status_led}, 4'h0);
    slave_address = 5'h05;
    send(3, 4'h0);
    idle(CL - 3);
    send(2, 4'h0);
    idle(CL - 3);
    chk({3'h0, red_status_led}, 4'h0);
    idle(8);
    chk({2'h0, no_exchange_flag, red_status_led}, 4'h3);
    send(2, 4'h0);
    idle(1);
    chk({3'h0, red_status_led}, 4'h0);
    send(1, 4'h0);
    idle(CL + 5);
    chk({3'h0, red_status_led}, 4'h0);
    $display("test monitor done");
    for (int m = 0; m < 3; m++) begin
      watchdog_enable_flag = (m == 0);
      port0_watchdog_select = (m > 0);
      parameter_port_bit_zero = (m == 1);
      do_reset();
      send(3, 4'h0);
      idle(CL + 8);
      chk({1'b0, wd_seen, data_exchange_blocked, red_status_led}, (m < 2) ? 4'h6 : 4'h1);
      if (m < 2) begin
        send(2, 4'h0);
        idle(1);
        chk({3'h0, acc_seen}, 4'h0);
        send(3, 4'h0);
        send(2, 4'h0);
        idle(1);
        chk({2'h0, acc_seen, data_exchange_blocked}, 4'h2);
      end
    end
    $display("test watchdog done");
    {watchdog_enable_flag, port0_watchdog_select, parameter_port_bit_zero} = 3'h4;
    profile_code = NIBBLE_PROFILE_CODE;
    for (int m = 0; m < 2; m++) begin
      ext_addr_nibble_mode = m[0];
      do_reset();
      for (int k = 0; k < 4; k++) begin
        send(4, 4'(k));
        idle(10);
      end
      chk({2'h0, wd_seen, toggle_watchdog_armed}, 4'h1);
      idle(TL + 5);
      chk({3'h0, wd_seen}, {3'h0, m[0]});
      send(1, 4'h0);
      chk({3'h0, toggle_watchdog_armed}, 4'h0);
    end
    {watchdog_enable_flag, ext_addr_nibble_mode} = 2'h0;
    $display("test toggle done");
    send(5, 4'h0);
    chk(ext_one_reply, 4'h9);
    send(6, 4'h6);
    chk({2'h0, nvm_write_start, ext_one_reply_valid}, 4'h3);
    chk(nvm_write_data, 4'h6);
    ext_code_lock_flag = 1'b1;
    for (int m = 0; m < 2; m++) begin
      ext_addr_mode = m[0];
      send(5, 4'h0);
      chk(ext_one_reply, {m[0] ? 1'b1 : 1'b0, 3'h3});
      send(6, 4'hC);
      chk({2'h0, nvm_write_start, ext_one_reply_valid}, 4'h0);
    end
    i_master_model.ab_change(1'b0);
    chk({2'h0, nvm_write_start, ext_one_reply_valid}, 4'h3);
    chk(nvm_write_data, 4'h3);
    $display("test extension done");
    results();
  end
endmodule
`default_nettype wire
